// ===== ttm_defines.svh
`ifndef TTM_DEFINES_SVH
`define TTM_DEFINES_SVH
////////////////////////////////////////////////////////////////////////////////
// Device address spaces
`define TTM_SPACE_PCI 1'b0
`define TTM_SPACE_MEM 1'b1
// Device register byte addresses
`define TTM_ADR_ERROR_STATUS 12'h0C8
`define TTM_ADR_SMI_COMMAND 12'h0CC
`define TTM_ADR_THERMAL_CONTROL_ONE 12'hCD8
`define TTM_ADR_THERMAL_CONTROL_TWO 12'hCD9
`define TTM_ADR_THERMAL_STATUS 12'hCDA
`define TTM_ADR_TRIP_POINTS 12'hCDC
`define TTM_ADR_CALIBRATION_OFFSET 12'hCE2
`define TTM_ADR_HARDWARE_PROTECTION 12'hCE4
`define TTM_ADR_THERMAL_INTERRUPT_STATUS 12'hCEA
`define TTM_ADR_THERMAL_SMI_COMMAND 12'hCF1
// Byte lanes counted from the access address
`define TTM_BE_BYTE0 4'h1
`define TTM_BE_BYTE1 4'h2
`define TTM_BE_HALF0 4'h3
// Values written to the device
`define TTM_VAL_SENSOR_ON 8'h99
`define TTM_VAL_CAT_CODE 8'h2C
`define TTM_VAL_THERMO_MODE 8'h04
`define TTM_VAL_HALT_ON_CAT 8'h08
`define TTM_VAL_HALT_LOCKED 8'h09
`define TTM_VAL_HOT_SMI_ON 8'h02
`define TTM_VAL_SMI_THERMAL 16'h0800
`define TTM_VAL_GLOBAL_LOCK 8'h80
`define TTM_VAL_ERR_CLEAR 16'h0800
`define TTM_VAL_HOT_EV_CLEAR 16'h0100
`define TTM_HOT_IND_BIT 7
// Hot code window and code ceiling
`define TTM_HOT_CODE_MIN 8'h37
`define TTM_HOT_CODE_MAX 8'h4D
`define TTM_CODE_CEIL 8'h80
`define TTM_HOT_CODE_RESET 8'h40
// Controller register byte addresses
`define TTM_SW_CTRL 8'h00
`define TTM_SW_HOT 8'h04
`define TTM_SW_STATUS 8'h08
`define TTM_SW_IRQ_STAT 8'h0C
`define TTM_SW_IRQ_MASK 8'h10
// Fields and counts
`define TTM_CTRL_START 0
`define TTM_CTRL_SERVICE 1
`define TTM_EV_DONE 0
`define TTM_EV_HOT 1
`define TTM_EV_FAULT 2
`define TTM_EV_COUNT 3
`define TTM_ACK_WAIT 64
`endif

// ===== ttm_pkg.sv
package ttm_pkg;
  // Sequencer states, Gray along the setup path
  typedef enum logic [3:0] {
    TTM_IDLE = 4'h0,
    TTM_CTL1 = 4'h1,
    TTM_HOT = 4'h3,
    TTM_CAT = 4'h2,
    TTM_CTL2 = 4'h6,
    TTM_HALT = 4'h7,
    TTM_PLOCK = 4'h5,
    TTM_TSMI = 4'h4,
    TTM_SMIC = 4'hC,
    TTM_GLOCK = 4'hD,
    TTM_READY = 4'hF,
    TTM_EVCLR = 4'hE,
    TTM_ERR = 4'hA,
    TTM_STATRD = 4'hB
  } ttm_state_type;
  // One device access
  typedef struct packed {
    logic space;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic rd;
  } ttm_acc_type;
endpackage : ttm_pkg

// ===== ttm_acc_if.sv
interface ttm_acc_if;
  import ttm_pkg::*;
  logic req;
  ttm_acc_type acc;
  logic done;
  logic err;
  logic [31:0] rdata;
  modport ctl (output req, output acc, input done, input err, input rdata);
  modport port (input req, input acc, output done, output err, output rdata);
endinterface : ttm_acc_if

// ===== ttm_dev_port.sv
`include "ttm_defines.svh"
module ttm_dev_port #(
  parameter int TIMEOUT = `TTM_ACK_WAIT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Sequencer side
  ttm_acc_if.port acc,
  // Device side
  output logic dev_space,
  output logic [11:0] dev_addr,
  output logic [31:0] dev_wdata,
  output logic [3:0] dev_be,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [31:0] dev_rdata,
  input wire logic dev_ack
);
  import ttm_pkg::*;
  logic busy_r;
  logic [15:0] wait_r;
  wire take = !busy_r && acc.req;
  wire late = busy_r && !dev_ack && (wait_r == 16'(TIMEOUT - 1));
  ////////////////////////////////////////////////////////////////////////////
  // Strobe and address, one cycle of strobe per access
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      {dev_space, dev_addr, dev_wdata, dev_be} <= '0;
      dev_wr <= 1'b0;
      dev_rd <= 1'b0;
    end
    else
    begin
      dev_wr <= take && !acc.acc.rd;
      dev_rd <= take && acc.acc.rd;
      if (take)
        {dev_space, dev_addr, dev_wdata, dev_be} <= {acc.acc.space, acc.acc.addr, acc.acc.wdata, acc.acc.be};
    end
  end
  // Wait for the answer; a silent device must not hang the sequencer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
      wait_r <= 16'h0;
      acc.done <= 1'b0;
      acc.err <= 1'b0;
      acc.rdata <= 32'h0;
    end
    else
    begin
      acc.done <= busy_r && dev_ack;
      acc.err <= late;
      wait_r <= take ? 16'h0 : wait_r + 16'h1;
      if (busy_r && dev_ack)
        acc.rdata <= dev_rdata;
      busy_r <= take || (busy_r && !dev_ack && !late);
    end
  end
  // Strobes are single pulses
  a_strobe_pulse: assert property (@(posedge mclk) disable iff (rst)
    (dev_wr || dev_rd) |=> !(dev_wr || dev_rd))
    else $error("device strobe longer than one cycle");
endmodule : ttm_dev_port

// ===== ttm_irq.sv
module ttm_irq #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Events and software access
  input wire logic [W-1:0] ev,
  input wire logic rd_clr,
  input wire logic [W-1:0] mask,
  // Status and interrupt
  output logic [W-1:0] stat,
  output logic irq
);
  logic [W-1:0] stat_nxt;
  // A new event beats the clear of the same read
  assign stat_nxt = (stat & ~{W{rd_clr}}) | ev;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      stat <= '0;
      irq <= 1'b0;
    end
    else
    begin
      stat <= stat_nxt;
      irq <= |(stat_nxt & mask);
    end
  end
  // Interrupt tracks the status masked by the mask of the cycle before
  a_irq_level: assert property (@(posedge mclk) disable iff (rst)
    ##1 (irq == |(stat & $past(mask))))
    else $error("interrupt does not follow masked status");
  // Events are never lost
  a_event_kept: assert property (@(posedge mclk) disable iff (rst)
    (|ev) |=> ((stat & $past(ev)) == $past(ev)))
    else $error("event lost in status");
endmodule : ttm_irq

// ===== ttm_top.sv
// Operation
// - Hot trip kept between 85 and 105 degrees
// - Codes 0 to 128, higher means cooler
// - Catastrophic code is always 2Ch
// - First control register written with 99h
// - Second control low nibble written with 04h
// - Protection register written with 08h
// - Protection lock bit 0 freezes halt setting
// - Thermal interrupt command written with 02h
// - Calibration bit 7 locks remaining settings
// - Hot event bit cleared by writing one
// - Global event bit 11 cleared by one
// - Setup follows the fixed nine step order
`include "ttm_defines.svh"
module ttm_top #(
  parameter logic [7:0] HOT_RESET = `TTM_HOT_CODE_RESET,
  parameter int ACK_WAIT = `TTM_ACK_WAIT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Software port
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic irq,
  // Device register port
  output logic dev_space,
  output logic [11:0] dev_addr,
  output logic [31:0] dev_wdata,
  output logic [3:0] dev_be,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [31:0] dev_rdata,
  input wire logic dev_ack,
  // Device management interrupt
  input wire logic sys_mgmt_irq_n
);
  import ttm_pkg::*;

  ttm_acc_if acc_if ();
  ttm_state_type state_r;
  ttm_state_type state_nxt;
  logic pend_r;
  logic req_r;
  logic service_r;
  logic [7:0] hot_r;
  logic [`TTM_EV_COUNT-1:0] mask_r;
  logic [`TTM_EV_COUNT-1:0] irq_stat;
  logic [`TTM_EV_COUNT-1:0] ev;
  logic plock_r;
  logic glock_r;
  logic smic_done_r;
  logic fault_r;
  logic hot_ind_r;
  logic [7:0] therm_stat_r;

  ////////////////////////////////////////////////////////////////////////////
  // Access for each step of the setup and service walk
  function automatic ttm_acc_type step_acc(input ttm_state_type s, input logic [7:0] hot);
    ttm_acc_type a;
    a = '0;
    a.space = `TTM_SPACE_MEM;
    a.be = `TTM_BE_BYTE0;
    case (s)
      TTM_CTL1:
      begin
        a.addr = `TTM_ADR_THERMAL_CONTROL_ONE;
        a.wdata = {24'h0, `TTM_VAL_SENSOR_ON};
      end
      TTM_HOT:
      begin
        a.addr = `TTM_ADR_TRIP_POINTS;
        a.wdata = {16'h0, hot, 8'h00};
        a.be = `TTM_BE_BYTE1;
      end
      TTM_CAT:
      begin
        a.addr = `TTM_ADR_TRIP_POINTS;
        a.wdata = {24'h0, `TTM_VAL_CAT_CODE};
      end
      TTM_CTL2:
      begin
        a.addr = `TTM_ADR_THERMAL_CONTROL_TWO;
        a.wdata = {24'h0, `TTM_VAL_THERMO_MODE};
      end
      TTM_HALT:
      begin
        a.addr = `TTM_ADR_HARDWARE_PROTECTION;
        a.wdata = {24'h0, `TTM_VAL_HALT_ON_CAT};
      end
      TTM_PLOCK:
      begin
        // Halt bit rewritten with the lock so it is frozen set
        a.addr = `TTM_ADR_HARDWARE_PROTECTION;
        a.wdata = {24'h0, `TTM_VAL_HALT_LOCKED};
      end
      TTM_TSMI:
      begin
        a.addr = `TTM_ADR_THERMAL_SMI_COMMAND;
        a.wdata = {24'h0, `TTM_VAL_HOT_SMI_ON};
      end
      TTM_SMIC:
      begin
        a.space = `TTM_SPACE_PCI;
        a.addr = `TTM_ADR_SMI_COMMAND;
        a.wdata = {16'h0, `TTM_VAL_SMI_THERMAL};
        a.be = `TTM_BE_HALF0;
      end
      TTM_GLOCK:
      begin
        a.addr = `TTM_ADR_CALIBRATION_OFFSET;
        a.wdata = {24'h0, `TTM_VAL_GLOBAL_LOCK};
      end
      TTM_EVCLR:
      begin
        a.addr = `TTM_ADR_THERMAL_INTERRUPT_STATUS;
        a.wdata = {16'h0, `TTM_VAL_HOT_EV_CLEAR};
        a.be = `TTM_BE_HALF0;
      end
      TTM_ERR:
      begin
        a.space = `TTM_SPACE_PCI;
        a.addr = `TTM_ADR_ERROR_STATUS;
        a.wdata = {16'h0, `TTM_VAL_ERR_CLEAR};
        a.be = `TTM_BE_HALF0;
      end
      TTM_STATRD:
      begin
        a.addr = `TTM_ADR_THERMAL_STATUS;
        a.rd = 1'b1;
      end
      default:
        a = '0;
    endcase
    return a;
  endfunction : step_acc

  // Successor of each access state
  function automatic ttm_state_type step_next(input ttm_state_type s);
    case (s)
      TTM_CTL1: return TTM_HOT;
      TTM_HOT: return TTM_CAT;
      TTM_CAT: return TTM_CTL2;
      TTM_CTL2: return TTM_HALT;
      TTM_HALT: return TTM_PLOCK;
      TTM_PLOCK: return TTM_TSMI;
      TTM_TSMI: return TTM_SMIC;
      TTM_SMIC: return TTM_GLOCK;
      TTM_EVCLR: return TTM_ERR;
      TTM_ERR: return TTM_STATRD;
      default: return TTM_READY;
    endcase
  endfunction : step_next

  ////////////////////////////////////////////////////////////////////////////
  // Software decode
  wire hit_ctrl = sw_addr == `TTM_SW_CTRL;
  wire hit_hot = sw_addr == `TTM_SW_HOT;
  wire hit_stat = sw_addr == `TTM_SW_STATUS;
  wire hit_irqs = sw_addr == `TTM_SW_IRQ_STAT;
  wire hit_mask = sw_addr == `TTM_SW_IRQ_MASK;
  wire start = sw_wr && hit_ctrl && sw_wdata[`TTM_CTRL_START];
  // Codes past the ceiling are meaningless, outside the window too hot or cold
  wire hot_ok = (hot_r >= `TTM_HOT_CODE_MIN) && (hot_r <= `TTM_HOT_CODE_MAX)
    && (hot_r <= `TTM_CODE_CEIL);
  wire idle = state_r == TTM_IDLE;
  wire ready = state_r == TTM_READY;
  wire in_step = !idle && !ready;
  // A locked device cannot be set up again, so a repeat start is a fault
  wire start_ok = start && idle && hot_ok && !glock_r;
  wire start_bad = start && !start_ok;
  wire smi_seen = ready && service_r && !sys_mgmt_irq_n;
  wire step_done = pend_r && acc_if.done;
  wire step_err = pend_r && acc_if.err;
  wire stat_rd_done = step_done && (state_r == TTM_STATRD);
  wire [31:0] status_word = {16'h0, therm_stat_r, 3'h0, hot_ind_r, fault_r, glock_r, ready, in_step};
  wire [31:0] rdata_nxt =
    !sw_rd ? 32'h0 :
    hit_ctrl ? {30'h0, service_r, 1'b0} :
    hit_hot ? {24'h0, hot_r} :
    hit_stat ? status_word :
    hit_irqs ? {{(32-`TTM_EV_COUNT){1'b0}}, irq_stat} :
    hit_mask ? {{(32-`TTM_EV_COUNT){1'b0}}, mask_r} :
    32'h0;

  // Events for the interrupt block
  assign ev[`TTM_EV_DONE] = step_done && (state_r == TTM_GLOCK);
  assign ev[`TTM_EV_HOT] = stat_rd_done;
  assign ev[`TTM_EV_FAULT] = step_err || start_bad;

  // Next state of the sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      TTM_IDLE:
        if (start_ok)
          state_nxt = TTM_CTL1;
      TTM_READY:
        if (smi_seen)
          state_nxt = TTM_EVCLR;
      default:
        if (step_err)
          state_nxt = glock_r ? TTM_READY : TTM_IDLE;
        else if (step_done)
          state_nxt = step_next(state_r);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and access request
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= TTM_IDLE;
      pend_r <= 1'b0;
      req_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      req_r <= in_step && !pend_r && !req_r;
      pend_r <= (pend_r || req_r) && !step_done && !step_err;
    end
  end

  assign acc_if.req = req_r;
  assign acc_if.acc = step_acc(state_r, hot_r);

  // Lock mirrors, sticky until reset like the device's own
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      plock_r <= 1'b0;
      glock_r <= 1'b0;
      smic_done_r <= 1'b0;
    end
    else
    begin
      plock_r <= plock_r || (step_done && state_r == TTM_PLOCK);
      glock_r <= glock_r || (step_done && state_r == TTM_GLOCK);
      smic_done_r <= smic_done_r || (step_done && state_r == TTM_SMIC);
    end
  end

  // Fault flag and last thermal status read
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fault_r <= 1'b0;
      hot_ind_r <= 1'b0;
      therm_stat_r <= 8'h00;
    end
    else
    begin
      fault_r <= (fault_r && !start_ok) || ev[`TTM_EV_FAULT];
      if (stat_rd_done)
      begin
        therm_stat_r <= acc_if.rdata[7:0];
        hot_ind_r <= acc_if.rdata[`TTM_HOT_IND_BIT];
      end
    end
  end

  // Software registers; the hot code only changes while idle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      service_r <= 1'b0;
      hot_r <= HOT_RESET;
      mask_r <= '0;
      sw_rdata <= 32'h0;
    end
    else
    begin
      sw_rdata <= rdata_nxt;
      if (sw_wr && hit_ctrl)
        service_r <= sw_wdata[`TTM_CTRL_SERVICE];
      if (sw_wr && hit_hot && idle)
        hot_r <= sw_wdata[7:0];
      if (sw_wr && hit_mask)
        mask_r <= sw_wdata[`TTM_EV_COUNT-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device access engine
  ttm_dev_port #(
    .TIMEOUT(ACK_WAIT)
  ) u_port (
    .mclk(mclk),
    .rst(rst),
    .acc(acc_if.port),
    .dev_space(dev_space),
    .dev_addr(dev_addr),
    .dev_wdata(dev_wdata),
    .dev_be(dev_be),
    .dev_wr(dev_wr),
    .dev_rd(dev_rd),
    .dev_rdata(dev_rdata),
    .dev_ack(dev_ack)
  );

  // Interrupt status, cleared by reading it
  ttm_irq #(
    .W(`TTM_EV_COUNT)
  ) u_irq (
    .mclk(mclk),
    .rst(rst),
    .ev(ev),
    .rd_clr(sw_rd && hit_irqs),
    .mask(mask_r),
    .stat(irq_stat),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks on what reaches the device
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  wire wr_mem = dev_wr && dev_space == `TTM_SPACE_MEM;

  a_sensor_value: assert property (
    (wr_mem && dev_addr == `TTM_ADR_THERMAL_CONTROL_ONE) |-> dev_wdata[7:0] == `TTM_VAL_SENSOR_ON)
    else $error("wrong sensor enable value");

  a_cat_code: assert property (
    (wr_mem && dev_addr == `TTM_ADR_TRIP_POINTS && dev_be == `TTM_BE_BYTE0)
    |-> dev_wdata[7:0] == `TTM_VAL_CAT_CODE)
    else $error("catastrophic code not fixed");

  a_hot_window: assert property (
    (wr_mem && dev_addr == `TTM_ADR_TRIP_POINTS && dev_be == `TTM_BE_BYTE1)
    |-> dev_wdata[15:8] inside {[`TTM_HOT_CODE_MIN:`TTM_HOT_CODE_MAX]})
    else $error("hot code outside window");

  a_thermo_mode: assert property (
    (wr_mem && dev_addr == `TTM_ADR_THERMAL_CONTROL_TWO) |-> dev_wdata[3:0] == `TTM_VAL_THERMO_MODE)
    else $error("wrong thermometer mode");

  a_halt_kept: assert property (
    (wr_mem && dev_addr == `TTM_ADR_HARDWARE_PROTECTION)
    |-> dev_wdata[3] && (dev_wdata[0] == plock_r || $past(state_r) == TTM_PLOCK))
    else $error("halt bit dropped or lock out of step");

  a_hot_smi_on: assert property (
    (wr_mem && dev_addr == `TTM_ADR_THERMAL_SMI_COMMAND) |-> dev_wdata[7:0] == `TTM_VAL_HOT_SMI_ON)
    else $error("wrong hot interrupt command");

  a_lock_last: assert property (
    (wr_mem && dev_addr == `TTM_ADR_CALIBRATION_OFFSET) |-> smic_done_r && plock_r)
    else $error("global lock before earlier steps");

  a_clear_order: assert property (
    (state_r == TTM_ERR) |-> $past(state_r) inside {TTM_EVCLR, TTM_ERR})
    else $error("global flag cleared before hot event");

  a_no_reprogram: assert property (
    glock_r |-> !(state_r inside {TTM_CTL1, TTM_HOT, TTM_CAT, TTM_CTL2}))
    else $error("setup repeated after lock");

  a_start_walk: assert property (
    start_ok |=> (state_r == TTM_CTL1) ##1 req_r)
    else $error("start did not issue first step");
endmodule : ttm_top

// ===== ttm_dev_model.sv
////////////////////////////////////////////////////////////////////////////////
// Behavioural thermal device: register table, trip compare, hot interrupt
module ttm_dev_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port from the controller
  input wire logic dev_space,
  input wire logic [11:0] dev_addr,
  input wire logic [31:0] dev_wdata,
  input wire logic [3:0] dev_be,
  input wire logic dev_wr,
  input wire logic dev_rd,
  output logic [31:0] dev_rdata,
  output logic dev_ack,
  output logic sys_mgmt_irq_n,
  // Bench controls
  input wire logic [7:0] temp_code,
  input wire logic [3:0] ack_delay,
  input wire logic mute
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] err_r, smi_r, int_stat_r;
  logic [7:0] ctl_one_r, ctl_two_r, cal_off_r, prot_r, tsmi_r;
  logic [31:0] trip_r, rd_r;
  logic hot_r, halt_r;
  logic [4:0] cnt_r;
  int wr_count;
  ////////////////////////////////////////////////////////////////////////////////
  // Decode; a lower code means a hotter die, so reaching a code is at or below it
  wire glock = cal_off_r[7];
  wire [7:0] hot_code = trip_r[15:8];
  wire [7:0] cat_code = trip_r[7:0];
  wire hot_set = temp_code <= hot_code;
  wire hot_clr = temp_code > hot_code + 8'h02;  // Hysteresis band
  wire hot_irq = hot_set & !hot_r & tsmi_r[1] & smi_r[11] & !int_stat_r[8];
  // Released read bus shows the inverse so stale data never matches
  assign dev_rdata = dev_ack ? rd_r : ~rd_r;
  assign dev_ack = cnt_r == 5'h01;
  assign sys_mgmt_irq_n = !int_stat_r[8];
  ////////////////////////////////////////////////////////////////////////////////
  // Byte lane merge, lanes counted from the register base
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] w, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      if (be[i]) o[8*i +: 8] = w[8*i +: 8];
    return o;
  endfunction : mrg
  // Registers, ack countdown and trip logic; a halted device never answers
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      {err_r, smi_r, int_stat_r, ctl_one_r, ctl_two_r, cal_off_r, prot_r, tsmi_r} <= '0;
      {trip_r, rd_r, hot_r, halt_r, cnt_r} <= '0;
      wr_count <= 0;
    end
    else
    begin
      if (mute | halt_r) cnt_r <= 5'h00;
      else if (dev_wr | dev_rd) cnt_r <= {1'b0, ack_delay};
      else if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
      if (dev_rd)
        rd_r <= dev_addr == 12'hCDA ? {24'h0, hot_r, 7'h00} : {16'h0, int_stat_r};
      if (dev_wr & !halt_r)
      begin
        wr_count <= wr_count + 1;
        if (!dev_space && dev_addr == 12'h0C8) err_r <= err_r & ~dev_wdata[15:0];
        if (!dev_space && dev_addr == 12'h0CC) smi_r <= dev_wdata[15:0];
        if (dev_space && !glock)
          case (dev_addr)
            12'hCD8: ctl_one_r <= dev_wdata[7:0];
            12'hCD9: ctl_two_r[3:0] <= dev_wdata[3:0];
            12'hCDC: trip_r <= mrg(trip_r, dev_wdata, dev_be);
            12'hCE2: cal_off_r <= dev_wdata[7:0];
            12'hCF1: tsmi_r <= dev_wdata[7:0];
            default: ;
          endcase
        if (dev_space && dev_addr == 12'hCE4 && !prot_r[0]) prot_r <= dev_wdata[7:0];
        if (dev_space && dev_addr == 12'hCEA) int_stat_r <= int_stat_r & ~dev_wdata[15:0];
      end
      if (hot_set) hot_r <= 1'b1;
      else if (hot_clr) hot_r <= 1'b0;
      if (hot_irq)
      begin
        int_stat_r[8] <= 1'b1;
        err_r[11] <= 1'b1;
      end
      if (prot_r[3] && temp_code <= cat_code) halt_r <= 1'b1;
    end
endmodule : ttm_dev_model

// ===== ttm_top_bench.sv
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the trip point controller
module ttm_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rst = 1, sw_wr = 0, sw_rd = 0, mute = 0;
  logic [7:0] sw_addr = 8'h00, temp = 8'h7F;
  logic [31:0] sw_wdata = 32'h0, sw_rdata, dev_wdata, dev_rdata, d;
  logic [3:0] dev_be, ack_delay = 4'h3;
  logic [11:0] dev_addr;
  logic irq, dev_space, dev_wr, dev_rd, dev_ack, smi_n;
  int err_count = 0, compares = 0, cycles = 0, w0;
  // Clock and hang limit
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      close_out();
    end
  end
  ttm_top #(.ACK_WAIT(4)) u_dut (.mclk(mclk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .dev_space(dev_space),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_be(dev_be), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata), .dev_ack(dev_ack), .sys_mgmt_irq_n(smi_n));
  ttm_dev_model u_model (.mclk(mclk), .rst(rst), .dev_space(dev_space), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_be(dev_be), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
    .dev_ack(dev_ack), .sys_mgmt_irq_n(smi_n), .temp_code(temp), .ack_delay(ack_delay), .mute(mute));
  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles and comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic sw_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= v;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask : sw_write
  // Read data stand only in the cycle after the strobe
  task automatic sw_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge mclk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask : sw_read
  // Skips the fall lag of a just-cleared status before waiting
  task automatic wait_irq(input int n);
    repeat (2) @(posedge mclk);
    for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge mclk);
    check({31'h0, irq}, 32'h1);
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    logic [7:0] adrs [4] = '{8'h00, 8'h08, 8'h0C, 8'h14};
    foreach (adrs[i])
    begin
      sw_read(adrs[i], d);
      check(d, 32'h0);
    end
    sw_read(8'h04, d);
    check(d, 32'h40);
    $display("test reset done");
  endtask : t_reset
  // A start with a hot code outside the window is a fault; mask gates the interrupt
  task automatic t_refuse;
    sw_write(8'h04, 32'h36);
    sw_read(8'h04, d);
    check(d, 32'h36);
    sw_write(8'h00, 32'h1);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    sw_read(8'h08, d);
    check(d & 32'hB, 32'h8);
    sw_write(8'h10, 32'h4);
    wait_irq(4);
    sw_read(8'h0C, d);
    check(d, 32'h4);
    repeat (3) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    sw_write(8'h04, 32'h4E);
    sw_write(8'h00, 32'h1);
    sw_read(8'h0C, d);
    check(d, 32'h4);
    sw_write(8'h04, 32'h4D);
    sw_read(8'h04, d);
    check(d, 32'h4D);
    sw_write(8'h04, 32'h37);
    sw_read(8'h04, d);
    check(d, 32'h37);
    sw_write(8'h04, 32'h40);
    sw_write(8'h10, 32'h7);
    $display("test refuse done");
  endtask : t_refuse
  // A silent device aborts the walk back to idle
  task automatic t_timeout;
    mute <= 1'b1;
    sw_write(8'h00, 32'h1);
    wait_irq(100);
    sw_read(8'h0C, d);
    check(d, 32'h4);
    sw_read(8'h08, d);
    check(d & 32'h3, 32'h0);
    mute <= 1'b0;
    $display("test timeout done");
  endtask : t_timeout
  // Full setup with slow answers; device values prove order and locks
  task automatic t_setup;
    sw_write(8'h00, 32'h1);
    wait_irq(400);
    sw_read(8'h0C, d);
    check(d, 32'h1);
    check(u_model.ctl_one_r, 32'h99);
    check(u_model.trip_r, 32'h402C);
    check(u_model.ctl_two_r, 32'h04);
    check(u_model.prot_r, 32'h09);
    check(u_model.tsmi_r, 32'h02);
    check(u_model.smi_r, 32'h0800);
    check(u_model.cal_off_r, 32'h80);
    sw_read(8'h08, d);
    check(d & 32'h7, 32'h6);
    $display("test setup done");
  endtask : t_setup
  // Once locked, new walks and hot code writes are refused
  task automatic t_locked;
    w0 = u_model.wr_count;
    sw_write(8'h00, 32'h1);
    wait_irq(20);
    sw_read(8'h0C, d);
    check(d, 32'h4);
    check(u_model.wr_count, w0);
    sw_write(8'h04, 32'h45);
    sw_read(8'h04, d);
    check(d, 32'h40);
    $display("test locked done");
  endtask : t_locked
  // Hot crossing is serviced: events cleared, indicator reported
  task automatic t_hot;
    sw_write(8'h00, 32'h2);
    temp <= 8'h30;
    wait_irq(400);
    sw_read(8'h0C, d);
    check(d, 32'h2);
    sw_read(8'h08, d);
    check(d & 32'hFFF7, 32'h8016);
    check(u_model.int_stat_r, 32'h0);
    check(u_model.err_r, 32'h0);
    temp <= 8'h7F;
    $display("test hot done");
  endtask : t_hot
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_refuse();
    t_timeout();
    t_setup();
    t_locked();
    t_hot();
    close_out();
  end
endmodule : ttm_top_bench
